// ### include/ixseq_pkg.sv
package ixseq_pkg;

  // ==========================================================
  // bus constants
  localparam logic [15:0] ADDR_DUMMY  = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [15:0] PFX_STEP    = 16'h0002;
  localparam logic [15:0] MASK_STEP   = 16'h0002;
  localparam logic [15:0] BROFF_STEP  = 16'h0003;
  localparam logic [15:0] RET_STEP    = 16'h0002;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  // ==========================================================
  // opcode encodings
  localparam logic [7:0] PFX_1A      = 8'h1A;
  localparam logic [7:0] PFX_CD      = 8'hCD;
  localparam logic [7:0] OPC_LDY2    = 8'hEE;
  localparam logic [7:0] OPC_STY2    = 8'hEF;
  localparam logic [7:0] OPC_JMP     = 8'h6E;
  localparam logic [7:0] OPC_TST     = 8'h6D;
  localparam logic [7:0] OPC_JSR     = 8'hAD;
  localparam logic [7:0] OPC_CMP16   = 8'hAC;
  localparam logic [7:0] OPC_SUBTRACT_DOUBLE    = 8'hA3;
  localparam logic [7:0] OPC_ADD_DOUBLE    = 8'hE3;
  localparam logic [7:0] OPC_STORE_ACCUMULATOR_A    = 8'hA7;
  localparam logic [7:0] OPC_STORE_ACCUMULATOR_B    = 8'hE7;
  localparam logic [7:0] OPC_LDD     = 8'hEC;
  localparam logic [7:0] OPC_LDS     = 8'hAE;
  localparam logic [7:0] OPC_LDX     = 8'hEE;
  localparam logic [7:0] OPC_STD     = 8'hED;
  localparam logic [7:0] OPC_STS     = 8'hAF;
  localparam logic [7:0] OPC_STX     = 8'hEF;
  localparam logic [7:0] OPC_BIT_SET_OP    = 8'h1C;
  localparam logic [7:0] OPC_BIT_CLEAR_OP    = 8'h1D;
  localparam logic [7:0] OPC_BRANCH_IF_BITS_SET   = 8'h1E;
  localparam logic [7:0] OPC_BRANCH_IF_BITS_CLEAR   = 8'h1F;
  localparam logic [3:0] NIB_RMW     = 4'h6;
  localparam logic [3:0] NIB_ALU_A   = 4'hA;
  localparam logic [3:0] NIB_ALU_B   = 4'hE;
  // one bit per low nibble that belongs to the group
  localparam logic [15:0] RMW_MAP    = 16'h97D9;
  localparam logic [15:0] ALU_MAP    = 16'h0F77;

  // ==========================================================
  // cycle counts per group
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;
  localparam logic [3:0] CYC_JMP     = 4'h3;
  localparam logic [3:0] CYC_SHORT   = 4'h4;
  localparam logic [3:0] CYC_LD16    = 4'h5;
  localparam logic [3:0] CYC_PFX16   = 4'h6;
  localparam logic [3:0] CYC_AR16    = 4'h6;
  localparam logic [3:0] CYC_CP16P   = 4'h7;
  localparam logic [3:0] CYC_JSR     = 4'h6;
  localparam logic [3:0] CYC_BIT     = 4'h7;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    G_ILL, G_JMP, G_ALU8, G_RMW, G_TST, G_ST8, G_LD16, G_ST16,
    G_AR16, G_CP16P, G_LDY, G_STY, G_JSR, G_BIT, G_BRB
  } ixseq_grp_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_OPC2, ST_OFS, ST_DUM1, ST_OP_HI, ST_OP_LO,
    ST_MASK, ST_BROFF, ST_DUM2, ST_DUM3, ST_RESULT, ST_STK_LO, ST_STK_HI
  } ixseq_state_type;

endpackage : ixseq_pkg

// ### include/ixseq_dec_if.sv
`timescale 1ns/1ns
interface ixseq_dec_if;
  import ixseq_pkg::*;
  logic          has_prefix;
  logic [7:0]    prefix;
  logic [7:0]    opcode;
  logic          is_prefix;
  ixseq_grp_type grp;

  modport seq (output has_prefix, prefix, opcode, input is_prefix, grp);
  modport dec (input has_prefix, prefix, opcode, output is_prefix, grp);
endinterface : ixseq_dec_if

// ### rtl/ixseq_decode.sv
`timescale 1ns/1ns
module ixseq_decode (
  ixseq_dec_if.dec dec_if
);
  import ixseq_pkg::*;

  // ==========================================================
  // opcode to bus-cycle group
  function automatic ixseq_grp_type dec_grp(input logic       pfx_en,
                                            input logic [7:0] pfx,
                                            input logic [7:0] opc);
    ixseq_grp_type g;
    g = G_ILL;
    if (pfx_en)
    begin
      // other prefixed codes belong to other addressing modes
      if (pfx == PFX_1A && opc == OPC_LDY2)
        g = G_LDY;
      else if (pfx == PFX_1A && opc == OPC_STY2)
        g = G_STY;
      else if (opc == OPC_CMP16 && (pfx == PFX_1A || pfx == PFX_CD))
        g = G_CP16P;
    end
    else if (opc == OPC_JMP)
      g = G_JMP;
    else if (opc == OPC_TST)
      g = G_TST;
    else if (opc[7:4] == NIB_RMW && RMW_MAP[opc[3:0]])
      g = G_RMW;
    else if ((opc[7:4] == NIB_ALU_A || opc[7:4] == NIB_ALU_B) && ALU_MAP[opc[3:0]])
      g = G_ALU8;
    else if (opc inside {OPC_STORE_ACCUMULATOR_A, OPC_STORE_ACCUMULATOR_B})
      g = G_ST8;
    else if (opc inside {OPC_LDD, OPC_LDS, OPC_LDX})
      g = G_LD16;
    else if (opc inside {OPC_STD, OPC_STS, OPC_STX})
      g = G_ST16;
    else if (opc inside {OPC_SUBTRACT_DOUBLE, OPC_ADD_DOUBLE, OPC_CMP16})
      g = G_AR16;
    else if (opc == OPC_JSR)
      g = G_JSR;
    else if (opc inside {OPC_BIT_SET_OP, OPC_BIT_CLEAR_OP})
      g = G_BIT;
    else if (opc inside {OPC_BRANCH_IF_BITS_SET, OPC_BRANCH_IF_BITS_CLEAR})
      g = G_BRB;
    return g;
  endfunction : dec_grp

  assign dec_if.grp       = dec_grp(dec_if.has_prefix, dec_if.prefix, dec_if.opcode);
  assign dec_if.is_prefix = !dec_if.has_prefix
                            && (dec_if.opcode == PFX_1A || dec_if.opcode == PFX_CD);

endmodule : ixseq_decode

// ### rtl/ixseq_top.sv
`timescale 1ns/1ns
module ixseq_top (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // instruction request and register values
  input  wire logic                    start_i,
  input  wire logic [15:0]             pc_i,
  input  wire logic [15:0]             x_index_register_i,
  input  wire logic [15:0]             sp_i,
  input  wire logic [15:0]             store_data_i,
  input  wire logic [7:0]              result_i,
  output logic                         ready_o,
  // processor bus
  output logic [15:0]                  addr_o,
  output logic                         rw_o,
  output logic [7:0]                   data_o,
  output logic                         bus_cycle_o,
  input  wire logic [7:0]              data_i,
  // captured instruction bytes, decoded group and completion pulses
  output logic [7:0]                   opcode_o,
  output logic [7:0]                   prebyte_o,
  output logic [15:0]                  operand_o,
  output logic [7:0]                   mask_o,
  output logic [7:0]                   branch_offset_o,
  output ixseq_pkg::ixseq_grp_type     group_o,
  output logic                         done_o,
  output logic                         illegal_o
);
  import ixseq_pkg::*;

  // ==========================================================
  // state
  ixseq_state_type state_ff, nxt_state;
  ixseq_grp_type   grp_ff, cur_grp;
  logic [15:0]     pc_ff, nxt_pc, ea_ff, nxt_ea, addr_ff, ret_addr;
  logic [7:0]      offset_ff, opcode_ff, prebyte_ff, mask_ff, broff_ff, dout_ff;
  logic [15:0]     operand_ff;
  logic            pfx_ff, nxt_pfx, rw_ff, done_ff, ill_ff, take;
  logic [3:0]      cnt_ff, nxt_cnt;
  ixseq_dec_if     dec_if ();

  ixseq_decode u_decode (
    .dec_if (dec_if.dec)
  );

  // ==========================================================
  // decode hookup
  assign dec_if.has_prefix = (state_ff == ST_OPC2);
  assign dec_if.prefix     = prebyte_ff;
  assign dec_if.opcode     = data_i;

  assign take     = start_i && (state_ff == ST_IDLE);
  assign cur_grp  = (state_ff == ST_OPC || state_ff == ST_OPC2) ? dec_if.grp : grp_ff;
  assign nxt_pc   = take ? pc_i : pc_ff;
  assign nxt_pfx  = take ? 1'b0 : ((state_ff == ST_OPC && dec_if.is_prefix) ? 1'b1 : pfx_ff);
  assign nxt_ea   = (state_ff == ST_OFS) ? x_index_register_i + {BYTE_ZERO, data_i}
                                         : ea_ff;
  assign ret_addr = nxt_pc + RET_STEP;

  // ==========================================================
  // sequencing per group
  function automatic ixseq_state_type next_st(input ixseq_state_type st,
                                              input ixseq_grp_type   g,
                                              input logic            go,
                                              input logic            pfx_seen);
    ixseq_state_type n;
    n = ST_IDLE;
    unique case (st)
      ST_IDLE:   n = go ? ST_OPC : ST_IDLE;
      ST_OPC:    n = pfx_seen ? ST_OPC2 : ((g == G_ILL) ? ST_IDLE : ST_OFS);
      ST_OPC2:   n = (g == G_ILL) ? ST_IDLE : ST_OFS;
      ST_OFS:    n = ST_DUM1;
      ST_DUM1:   n = (g == G_JMP) ? ST_IDLE : ST_OP_HI;
      ST_OP_HI:
      begin
        if (g inside {G_LD16, G_LDY, G_ST16, G_STY, G_AR16, G_CP16P})
          n = ST_OP_LO;
        else if (g inside {G_RMW, G_TST})
          n = ST_DUM2;
        else if (g == G_JSR)
          n = ST_STK_LO;
        else if (g inside {G_BIT, G_BRB})
          n = ST_MASK;
        else
          n = ST_IDLE;
      end
      ST_OP_LO:  n = (g inside {G_AR16, G_CP16P}) ? ST_DUM2 : ST_IDLE;
      ST_MASK:   n = (g == G_BIT) ? ST_DUM2 : ST_BROFF;
      ST_BROFF:  n = ST_DUM2;
      ST_DUM2:
      begin
        if (g inside {G_RMW, G_BIT})
          n = ST_RESULT;
        else if (g == G_TST)
          n = ST_DUM3;
        else
          n = ST_IDLE;
      end
      ST_STK_LO: n = ST_STK_HI;
      ST_DUM3, ST_RESULT, ST_STK_HI: n = ST_IDLE;
    endcase
    return n;
  endfunction : next_st

  function automatic logic [15:0] addr_of(input ixseq_state_type st,
                                          input logic [15:0]     pc,
                                          input logic            pfx,
                                          input logic [15:0]     ea,
                                          input logic [15:0]     sp);
    logic [15:0] a;
    a = ADDR_DUMMY;
    unique case (st)
      ST_OPC:               a = pc;
      ST_OPC2:              a = pc + ADDR_STEP;
      ST_OFS:               a = pfx ? pc + PFX_STEP : pc + ADDR_STEP;
      ST_OP_HI, ST_RESULT:  a = ea;
      ST_OP_LO:             a = ea + ADDR_STEP;
      ST_MASK:              a = pc + MASK_STEP;
      ST_BROFF:             a = pc + BROFF_STEP;
      ST_STK_LO:            a = sp;
      ST_STK_HI:            a = sp - ADDR_STEP;
      ST_IDLE, ST_DUM1, ST_DUM2, ST_DUM3: a = ADDR_DUMMY;
    endcase
    return a;
  endfunction : addr_of

  // writes: results, stacked return address, stores at the indexed address
  function automatic logic is_write(input ixseq_state_type st, input ixseq_grp_type g);
    return (st inside {ST_RESULT, ST_STK_LO, ST_STK_HI})
           || ((st inside {ST_OP_HI, ST_OP_LO}) && (g inside {G_ST8, G_ST16, G_STY}));
  endfunction : is_write

  wire ixseq_state_type nxt_st_w  = next_st(state_ff, cur_grp, take, dec_if.is_prefix);
  wire logic            nxt_rw    = !is_write(nxt_st_w, cur_grp);
  wire logic [15:0]     nxt_addr  = addr_of(nxt_st_w, nxt_pc, nxt_pfx, nxt_ea, sp_i);
  wire logic [7:0]      nxt_dout  =
      (nxt_st_w == ST_OP_HI && cur_grp == G_ST8)  ? store_data_i[7:0]  :
      (nxt_st_w == ST_OP_HI && !nxt_rw)           ? store_data_i[15:8] :
      (nxt_st_w == ST_OP_LO && !nxt_rw)           ? store_data_i[7:0]  :
      (nxt_st_w == ST_RESULT)                     ? result_i           :
      (nxt_st_w == ST_STK_LO)                     ? ret_addr[7:0]      :
      (nxt_st_w == ST_STK_HI)                     ? ret_addr[15:8]     : BYTE_ZERO;

  assign nxt_state = nxt_st_w;
  assign nxt_cnt   = (nxt_st_w == ST_IDLE) ? CNT_ZERO
                   : (state_ff == ST_IDLE) ? CNT_ONE : cnt_ff + CNT_ONE;

  // ==========================================================
  // bus registers: outputs change only on the edge that opens a cycle, or at once when rst_n_i falls
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= ST_IDLE;
      addr_ff  <= ADDR_DUMMY;
      rw_ff    <= 1'b1;
      dout_ff  <= BYTE_ZERO;
      cnt_ff   <= CNT_ZERO;
      pc_ff    <= WORD_ZERO;
      pfx_ff   <= 1'b0;
      ea_ff    <= WORD_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      rw_ff    <= nxt_rw;
      dout_ff  <= nxt_dout;
      cnt_ff   <= nxt_cnt;
      pc_ff    <= nxt_pc;
      pfx_ff   <= nxt_pfx;
      ea_ff    <= nxt_ea;
    end
  end

  // ==========================================================
  // captured bytes; dummy-cycle data is never sampled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      grp_ff     <= G_ILL;
      opcode_ff  <= BYTE_ZERO;
      prebyte_ff <= BYTE_ZERO;
      offset_ff  <= BYTE_ZERO;
      operand_ff <= WORD_ZERO;
      mask_ff    <= BYTE_ZERO;
      broff_ff   <= BYTE_ZERO;
    end
    else
    begin
      if (take)
        prebyte_ff <= BYTE_ZERO;
      else if (state_ff == ST_OPC && dec_if.is_prefix)
        prebyte_ff <= data_i;
      if ((state_ff == ST_OPC && !dec_if.is_prefix) || state_ff == ST_OPC2)
      begin
        grp_ff    <= dec_if.grp;
        opcode_ff <= data_i;
      end
      if (state_ff == ST_OFS)
        offset_ff <= data_i;
      if (state_ff == ST_OP_HI && rw_ff)
        operand_ff <= {BYTE_ZERO, data_i};
      if (state_ff == ST_OP_LO && rw_ff)
        operand_ff <= {operand_ff[7:0], data_i};
      if (state_ff == ST_MASK)
        mask_ff <= data_i;
      if (state_ff == ST_BROFF)
        broff_ff <= data_i;
    end
  end

  // ==========================================================
  // completion pulses
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_ff <= 1'b0;
      ill_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
      ill_ff  <= (state_ff inside {ST_OPC, ST_OPC2}) && !dec_if.is_prefix
                 && (dec_if.grp == G_ILL);
    end
  end

  assign ready_o         = (state_ff == ST_IDLE);
  assign addr_o          = addr_ff;
  assign rw_o            = rw_ff;
  assign data_o          = dout_ff;
  assign bus_cycle_o     = (cnt_ff != CNT_ZERO);
  assign opcode_o        = opcode_ff;
  assign prebyte_o       = prebyte_ff;
  assign operand_o       = operand_ff;
  assign mask_o          = mask_ff;
  assign branch_offset_o = broff_ff;
  assign group_o         = grp_ff;
  assign done_o          = done_ff;
  assign illegal_o       = ill_ff;

  // ==========================================================
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_prefixless_order;
    (cnt_ff == 4'h2 && !pfx_ff) |-> addr_o == pc_ff + ADDR_STEP ##1 addr_o == ADDR_DUMMY && rw_o;
  endproperty
  a_prefixless_order: assert property (p_prefixless_order) else $error("order after opcode");

  property p_short_len;
    done_o && (grp_ff inside {G_ALU8, G_ST8})
      |-> $past(cnt_ff) == CYC_SHORT && $past(rw_o) == (grp_ff != G_ST8);
  endproperty
  a_short_len: assert property (p_short_len) else $error("8-bit op length or rw");

  property p_ld16;
    done_o && grp_ff == G_LD16
      |-> $past(cnt_ff) == CYC_LD16 && $past(addr_o) == $past(addr_o, 2) + ADDR_STEP;
  endproperty
  a_ld16: assert property (p_ld16) else $error("16-bit load sequence");

  property p_ldy;
    done_o && grp_ff == G_LDY
      |-> $past(cnt_ff) == CYC_PFX16 && prebyte_o == PFX_1A && opcode_o == OPC_LDY2;
  endproperty
  a_ldy: assert property (p_ldy) else $error("Y load sequence");

  property p_st16;
    (grp_ff == G_ST16 && cnt_ff == CYC_SHORT) |-> !rw_o && addr_o == ea_ff
      ##1 !rw_o && cnt_ff == CYC_LD16 && addr_o == ea_ff + ADDR_STEP ##1 done_o;
  endproperty
  a_st16: assert property (p_st16) else $error("16-bit store sequence");

  property p_sty;
    (grp_ff == G_STY && cnt_ff == CYC_LD16) |-> !rw_o && data_o == store_data_i[15:8]
      ##1 !rw_o && addr_o == ea_ff + ADDR_STEP ##1 done_o && $past(cnt_ff) == CYC_PFX16;
  endproperty
  a_sty: assert property (p_sty) else $error("Y store sequence");

  property p_ar16;
    done_o && grp_ff == G_AR16 |-> $past(cnt_ff) == CYC_AR16 && $past(addr_o) == ADDR_DUMMY;
  endproperty
  a_ar16: assert property (p_ar16) else $error("16-bit arithmetic length");

  property p_cp16p;
    done_o && grp_ff == G_CP16P |-> $past(cnt_ff) == CYC_CP16P && $past(rw_o);
  endproperty
  a_cp16p: assert property (p_cp16p) else $error("prefixed compare length");

  property p_call_fetch;
    (grp_ff == G_JSR && cnt_ff == CYC_SHORT) |-> rw_o && addr_o == ea_ff;
  endproperty
  a_call_fetch: assert property (p_call_fetch) else $error("call target fetch");

  property p_call_stack;
    (grp_ff == G_JSR && cnt_ff == CYC_SHORT)
      |-> ##1 !rw_o && addr_o == sp_i && data_o == ret_addr[7:0]
      ##1 !rw_o && addr_o == sp_i - ADDR_STEP ##1 done_o && $past(cnt_ff) == CYC_JSR;
  endproperty
  a_call_stack: assert property (p_call_stack) else $error("return address stacking");

  property p_bit_ops;
    (grp_ff inside {G_BIT, G_BRB} && cnt_ff == CYC_LD16) |-> addr_o == pc_ff + MASK_STEP
      ##1 rw_o ##1 (rw_o == (grp_ff == G_BRB)) ##1 done_o && $past(cnt_ff) == CYC_BIT;
  endproperty
  a_bit_ops: assert property (p_bit_ops) else $error("bit op sequence");

  property p_index_sum;
    (cnt_ff == CYC_SHORT && !pfx_ff && grp_ff != G_ILL)
      |-> ea_ff == x_index_register_i + {BYTE_ZERO, offset_ff};
  endproperty
  a_index_sum: assert property (p_index_sum) else $error("effective address");

  property p_dummy_read;
    (bus_cycle_o && addr_o == ADDR_DUMMY) |-> rw_o;
  endproperty
  a_dummy_read: assert property (p_dummy_read) else $error("write at dummy address");

  c_call:   cover property (done_o && grp_ff == G_JSR);
  c_branch: cover property (done_o && grp_ff == G_BRB);
  c_ldy:    cover property (done_o && grp_ff == G_LDY);
  c_ill:    cover property (illegal_o);

endmodule : ixseq_top

// ### tb/ixseq_mem_model.sv
`timescale 1ns/1ns
// ==========================================
// program and data memory on the processor bus
module ixseq_mem_model (
  // clock
  input  wire logic        clk_i,
  // processor bus
  input  wire logic [15:0] addr_i,
  input  wire logic        rw_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        bus_cycle_i,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff = 8'h00;
  // idle bus shows the inverse, so a stale byte never passes for a read
  assign data_o = (bus_cycle_i && rw_i) ? mem[addr_i] : ~last_ff;
  always @(posedge clk_i)
  begin
    if (bus_cycle_i && !rw_i)
      mem[addr_i] <= data_i;
    last_ff <= data_o;
  end
endmodule : ixseq_mem_model

// ### tb/test_indexed_x_bus_cycle_sequencer.sv
`timescale 1ns/1ns
module test_indexed_x_bus_cycle_sequencer;
  import ixseq_pkg::*;
  // ==========================================
  // stimulus and observation
  localparam logic [15:0] PC_V = 16'h1000;
  localparam logic [15:0] X_V  = 16'hFF20;
  localparam logic [15:0] SP_V = 16'h01FF;
  // offset F0 on X FF20 wraps past the top of memory
  localparam logic [15:0] EA   = X_V + 16'h00F0;
  logic clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0;
  logic [15:0] pc_i = 16'h0000, sdat = 16'hB4E1;
  logic [7:0]  res = 8'hA5;
  logic [7:0]  rd_data, data_o, opcode_o, prebyte_o, mask_o, broff_o;
  logic [15:0] addr_o, operand_o;
  logic        ready_o, rw_o, bus_cycle_o, done_o, illegal_o;
  ixseq_grp_type group_o;
  int mismatches = 0;
  int comparisons = 0;
  logic [15:0] got_a[$], ex_a[$];
  logic        got_w[$];
  logic [7:0]  got_d[$];

  ixseq_top u_ixseq_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .pc_i(pc_i),
    .x_index_register_i(X_V), .sp_i(SP_V), .store_data_i(sdat), .result_i(res),
    .ready_o(ready_o), .addr_o(addr_o), .rw_o(rw_o), .data_o(data_o),
    .bus_cycle_o(bus_cycle_o), .data_i(rd_data), .opcode_o(opcode_o),
    .prebyte_o(prebyte_o), .operand_o(operand_o), .mask_o(mask_o),
    .branch_offset_o(broff_o), .group_o(group_o), .done_o(done_o), .illegal_o(illegal_o));
  ixseq_mem_model u_ixseq_mem_model (.clk_i(clk_i), .addr_i(addr_o), .rw_i(rw_o),
    .data_i(data_o), .bus_cycle_i(bus_cycle_o), .data_o(rd_data));

  always #4 clk_i = ~clk_i;

  // ==========================================
  // shared tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic run_instr(input logic [7:0] b0, b1, b2, b3);
    int i;
    u_ixseq_mem_model.mem[PC_V] = b0;
    u_ixseq_mem_model.mem[PC_V + 16'h0001] = b1;
    u_ixseq_mem_model.mem[PC_V + 16'h0002] = b2;
    u_ixseq_mem_model.mem[PC_V + 16'h0003] = b3;
    u_ixseq_mem_model.mem[EA] = 8'h5A;
    u_ixseq_mem_model.mem[EA + 16'h0001] = 8'hC3;
    got_a = {};
    got_w = {};
    got_d = {};
    for (i = 0; i < 20 && ready_o !== 1'b1; i++)
      @(posedge clk_i) #1;
    pc_i = PC_V;
    start_i = 1'b1;
    @(posedge clk_i) #1;
    start_i = 1'b0;
    for (i = 0; i < 12 && done_o !== 1'b1; i++)
    begin
      if (bus_cycle_o === 1'b1)
      begin
        got_a.push_back(addr_o);
        got_w.push_back(rw_o);
        got_d.push_back(data_o);
      end
      @(posedge clk_i) #1;
    end
    if (done_o !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH done expected 1 seen %b", done_o);
      test_done();
    end
  endtask : run_instr

  // bit k of ex_w is the read/write level of bus cycle k+1
  task automatic chk_trace(input logic [7:0] ex_w);
    chk("cycle count", 16'(ex_a.size()), 16'(got_a.size()));
    foreach (ex_a[i])
    begin
      chk("address", ex_a[i], got_a[i]);
      chk("read write", {15'h0000, ex_w[i]}, {15'h0000, got_w[i]});
    end
  endtask : chk_trace

  // ==========================================
  // scenarios
  task automatic t_short();
    logic [7:0] ops [3] = '{8'hA6, 8'hA7, 8'hE7};
    foreach (ops[k])
    begin
      run_instr(ops[k], 8'hF0, 8'h00, 8'h00);
      ex_a = {PC_V, PC_V + 16'h0001, ADDR_DUMMY, EA};
      chk_trace(k == 0 ? 8'h0F : 8'h07);
      if (k == 0)
        chk("byte operand", 16'h005A, {8'h00, operand_o[7:0]});
      else
        chk("byte store", {8'h00, sdat[7:0]}, {8'h00, got_d[3]});
    end
  endtask : t_short

  task automatic t_word();
    logic [7:0] ops [9] = '{8'hEC, 8'hAE, 8'hEE, 8'hED, 8'hAF, 8'hEF, 8'hE3, 8'hA3, 8'hAC};
    foreach (ops[k])
    begin
      run_instr(ops[k], 8'hF0, 8'h00, 8'h00);
      ex_a = {PC_V, PC_V + 16'h0001, ADDR_DUMMY, EA, EA + 16'h0001};
      if (k >= 6)
        ex_a.push_back(ADDR_DUMMY);
      chk_trace((k >= 3 && k < 6) ? 8'h07 : 8'h3F);
      if (k >= 3 && k < 6)
        chk("word store", sdat, {got_d[3], got_d[4]});
      else
        chk("word load", 16'h5AC3, operand_o);
    end
  endtask : t_word

  task automatic t_prefixed();
    logic [15:0] ops [4] = '{16'h1AEE, 16'h1AEF, 16'h1AAC, 16'hCDAC};
    foreach (ops[k])
    begin
      run_instr(ops[k][15:8], ops[k][7:0], 8'hF0, 8'h00);
      ex_a = {PC_V, PC_V + 16'h0001, PC_V + 16'h0002, ADDR_DUMMY, EA, EA + 16'h0001};
      if (k >= 2)
        ex_a.push_back(ADDR_DUMMY);
      chk_trace(k == 1 ? 8'h0F : 8'h7F);
      chk("prebyte", {8'h00, ops[k][15:8]}, {8'h00, prebyte_o});
      if (k == 1)
        chk("y store", sdat, {got_d[4], got_d[5]});
      else
        chk("y load", 16'h5AC3, operand_o);
    end
  endtask : t_prefixed

  // groups outside the plain load/store set, and a code that is not X-indexed
  task automatic t_other();
    logic [7:0]    ops [4] = '{8'h6E, 8'h60, 8'h6D, 8'h00};
    logic [7:0]    ws  [4] = '{8'h07, 8'h1F, 8'h3F, 8'h01};
    ixseq_grp_type exg [4] = '{G_JMP, G_RMW, G_TST, G_ILL};
    foreach (ops[k])
    begin
      run_instr(ops[k], 8'hF0, 8'h00, 8'h00);
      ex_a = {PC_V, PC_V + 16'h0001, ADDR_DUMMY};
      if (k == 1)
        ex_a = {ex_a, EA, ADDR_DUMMY, EA};
      else if (k == 2)
        ex_a = {ex_a, EA, ADDR_DUMMY, ADDR_DUMMY};
      else if (k == 3)
        ex_a = {PC_V};
      chk_trace(ws[k]);
      chk("group", 16'(exg[k]), 16'(group_o));
      chk("illegal", {15'h0000, k == 3}, {15'h0000, illegal_o});
      if (k == 1)
        chk("rmw result", {8'h00, res}, {8'h00, got_d[5]});
    end
  endtask : t_other

  // reset pulled two cycles after starting code 00, which has already ended as illegal: the bus must stay idle for two cycles after release
  task automatic t_reset();
    int i;
    pc_i = PC_V;
    start_i = 1'b1;
    @(posedge clk_i) #1;
    start_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b0;
    @(posedge clk_i) #1;
    rst_n_i = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk_i) #1;
      chk("reset addr", ADDR_DUMMY, addr_o);
      chk("reset rw", 16'h0001, {15'h0000, rw_o});
      chk("reset bus cycle", 16'h0000, {15'h0000, bus_cycle_o});
      chk("reset ready", 16'h0001, {15'h0000, ready_o});
      chk("reset done", 16'h0000, {15'h0000, done_o});
    end
  endtask : t_reset

  task automatic t_call();
    logic [15:0] ret;
    ret = PC_V + 16'h0002;
    run_instr(8'hAD, 8'hF0, 8'h00, 8'h00);
    ex_a = {PC_V, PC_V + 16'h0001, ADDR_DUMMY, EA, SP_V, SP_V - 16'h0001};
    chk_trace(8'h0F);
    chk("target opcode", 16'h005A, {8'h00, operand_o[7:0]});
    chk("stacked return", ret, {got_d[5], got_d[4]});
  endtask : t_call

  task automatic t_bits();
    logic [7:0] ops [4] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F};
    foreach (ops[k])
    begin
      run_instr(ops[k], 8'hF0, 8'h3C, 8'h12);
      ex_a = {PC_V, PC_V + 16'h0001, ADDR_DUMMY, EA, PC_V + 16'h0002};
      if (k < 2)
        ex_a = {ex_a, ADDR_DUMMY, EA};
      else
        ex_a = {ex_a, PC_V + 16'h0003, ADDR_DUMMY};
      chk_trace(k < 2 ? 8'h3F : 8'h7F);
      chk("mask", 16'h003C, {8'h00, mask_o});
      if (k < 2)
        chk("result write", {8'h00, res}, {8'h00, got_d[6]});
      else
        chk("branch offset", 16'h0012, {8'h00, broff_o});
    end
  endtask : t_bits

  initial
  begin
    u_ixseq_mem_model.mem[16'hFFFF] = 8'h77;
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_short();
    t_word();
    t_prefixed();
    t_other();
    t_reset();
    t_call();
    t_bits();
    test_done();
  end
endmodule : test_indexed_x_bus_cycle_sequencer
